// [test/llc_loopback_chk.sv]
`timescale 1ns/1ps
// =====================================================================
// port checker for the loopback controller
module llc_loopback_chk #(
  parameter int unsigned NUM_CH = 16
) (
  // watched clock, reset and controls
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [NUM_CH-1:0] i_analog_loop_enable,
  input wire logic [NUM_CH-1:0] i_manual_remote_loop_enable,
  input wire logic [NUM_CH-1:0] i_automatic_loop_enable,
  input wire logic [NUM_CH-1:0] i_inband_loop_code_activate,
  input wire logic [NUM_CH-1:0] i_sys_tx_data,
  input wire logic i_sys_rx_ready,
  // watched outputs
  input wire logic o_sys_rx_valid,
  input wire logic [NUM_CH-1:0] o_sys_rx_data,
  input wire logic o_line_tx_strobe,
  input wire logic [NUM_CH-1:0] o_tx_detect_data,
  input wire logic [NUM_CH-1:0] o_analog_loop_active,
  input wire logic [NUM_CH-1:0] o_remote_loop_active,
  input wire logic [NUM_CH-1:0] o_digital_loop_active,
  input wire logic [NUM_CH-1:0] o_automatic_loop_active_flag,
  input wire logic [NUM_CH-1:0] o_system_transmit_clock_ignored
);
  // one clock domain; $past guards skip the edge that leaves reset
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  analog_follow_a: assert property (!$past(i_srst) |->
    o_analog_loop_active == $past(i_analog_loop_enable)) else $error("analog state wrong");
  loop_exclusive_a: assert property (
    (o_analog_loop_active & (o_remote_loop_active | o_digital_loop_active)) == '0)
    else $error("analog loop not exclusive");
  remote_manual_a: assert property (!$past(i_srst) |->
    ($past(i_manual_remote_loop_enable & ~i_analog_loop_enable) & ~o_remote_loop_active) == '0)
    else $error("manual remote loop missing");
  clock_ignore_a: assert property (
    o_system_transmit_clock_ignored == o_remote_loop_active) else $error("clock ignore wrong");
  auto_stop_a: assert property (!$past(i_srst) && !$past(i_srst, 2) |->
    (~$past(i_automatic_loop_enable, 2) & o_automatic_loop_active_flag) == '0)
    else $error("automatic loop outlived enable");
  auto_entry_a: assert property ($rose(o_automatic_loop_active_flag[0]) |->
    $past(i_inband_loop_code_activate[0], 2) && $past(i_automatic_loop_enable[0], 2))
    else $error("automatic loop without code");
  rx_hold_a: assert property (o_sys_rx_valid && !i_sys_rx_ready |=>
    o_sys_rx_valid && $stable(o_sys_rx_data)) else $error("stalled word not held");
  strobe_pulse_a: assert property (o_line_tx_strobe |=> !o_line_tx_strobe)
    else $error("strobe longer than one cycle");
  tx_watch_a: assert property (o_line_tx_strobe |->
    o_tx_detect_data == $past(i_sys_tx_data)) else $error("tx detect stream wrong");
  dual_remote_a: assert property (!$past(i_srst) |->
    (o_remote_loop_active & o_digital_loop_active & ~$past(i_manual_remote_loop_enable)) == '0)
    else $error("dual loop without manual remote");
endmodule

bind llc_loopback llc_loopback_chk #(.NUM_CH(NUM_CH)) llc_loopback_chk_inst (.*);

// [test/llc_sys_sink.sv]
`timescale 1ns/1ps
// =====================================================================
// system-side receiver: takes words unless told to stall
module llc_sys_sink #(
  parameter int unsigned W = 16
) (
  // clock and stall request
  input wire logic i_ref_clk,
  input wire logic i_stall,
  // stream from the block
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  output logic [W-1:0] o_last
);
  // ready only moves with the bench stall, which changes after an edge
  assign o_ready = !i_stall;
  // keep the latest accepted word, taken at the accepting edge
  always @(posedge i_ref_clk) begin
    if (i_valid && o_ready) begin
      o_last <= i_data;
    end
  end
endmodule

// [test/test_line_loopback_control.sv]
`timescale 1ns/1ps
// =====================================================================
// loopback controller bench
module test_line_loopback_control;
  localparam logic [15:0] L = 16'h00FF, S = 16'h0F0F, RP = 16'h3333, TP = 16'hAAAA;
  // row: controls {analog,remote,digital,rxpat,txpat,rxais,txais}, expected selectors
  typedef struct packed {logic [6:0] c; logic [2:0] tx, rx, rd, wa, td, act;} llc_row_t;
  logic clk = 1'b0, srst = 1'b1, stall = 1'b0, rdy, valid, strobe;
  logic [15:0] analog_loop_enable = 16'h0, manual_remote_loop_enable = 16'h0, manual_digital_loop_enable = 16'h0, aen = 16'h0, pos = 16'h0;
  logic [15:0] act = 16'h0, dea = 16'h0, rpe = 16'h0, tpe = 16'h0, rai = 16'h0, tai = 16'h0;
  logic [15:0] rxd, last, ltx, rdet, watch, tdet, aa, ra, da, fl, ig;
  int errors = 0, compares = 0;
  llc_row_t r;
  // selector 7 means not checked in that row
  llc_row_t rows [13] = '{'{7'h00, 3'h1, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0},
    '{7'h03, 3'h4, 3'h4, 3'h7, 3'h7, 3'h7, 3'h0}, '{7'h73, 3'h1, 3'h1, 3'h7, 3'h1, 3'h7, 3'h4},
    '{7'h48, 3'h1, 3'h2, 3'h7, 3'h7, 3'h7, 3'h4}, '{7'h20, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2},
    '{7'h23, 3'h0, 3'h4, 3'h7, 3'h7, 3'h1, 3'h2}, '{7'h24, 3'h3, 3'h0, 3'h7, 3'h7, 3'h1, 3'h2},
    '{7'h10, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1}, '{7'h12, 3'h1, 3'h1, 3'h7, 3'h7, 3'h7, 3'h1},
    '{7'h1C, 3'h3, 3'h2, 3'h7, 3'h7, 3'h7, 3'h1}, '{7'h30, 3'h0, 3'h1, 3'h1, 3'h0, 3'h1, 3'h3},
    '{7'h37, 3'h0, 3'h1, 3'h7, 3'h7, 3'h1, 3'h3}, '{7'h38, 3'h0, 3'h2, 3'h7, 3'h7, 3'h7, 3'h3}};

  // short counts so automatic entry and line steps fit a short run
  llc_loopback #(.AUTO_HOLD_CYCLES(20), .LINE_DIV(4)) llc_loopback_inst (
    .i_ref_clk(clk), .i_srst(srst), .i_analog_loop_enable(analog_loop_enable),
    .i_manual_remote_loop_enable(manual_remote_loop_enable), .i_manual_digital_loop_enable(manual_digital_loop_enable),
    .i_automatic_loop_enable(aen), .i_pattern_detector_position(pos),
    .i_inband_loop_code_activate(act), .i_inband_loop_code_deactivate(dea),
    .i_rx_pattern_gen_enable(rpe), .i_rx_pattern_gen_data(RP),
    .i_tx_pattern_gen_enable(tpe), .i_tx_pattern_gen_data(TP),
    .i_rx_ais_gen_request(rai), .i_tx_ais_gen_request(tai),
    .i_line_rx_data(L), .i_sys_tx_data(S), .o_sys_rx_valid(valid), .o_sys_rx_data(rxd),
    .i_sys_rx_ready(rdy), .o_line_tx_strobe(strobe), .o_line_tx_data(ltx),
    .o_rx_detect_data(rdet), .o_rx_alarm_watch_data(watch), .o_tx_detect_data(tdet),
    .o_analog_loop_active(aa), .o_remote_loop_active(ra), .o_digital_loop_active(da),
    .o_automatic_loop_active_flag(fl), .o_system_transmit_clock_ignored(ig));
  llc_sys_sink llc_sys_sink_inst (.i_ref_clk(clk), .i_stall(stall), .i_valid(valid),
    .i_data(rxd), .o_ready(rdy), .o_last(last));

  // 50 MHz clock
  always #10 clk = ~clk;

  // =====================================================================
  // helpers
  function automatic logic [15:0] sel(input logic [2:0] k);
    case (k)
      3'h0: return L;
      3'h1: return S;
      3'h2: return RP;
      3'h3: return TP;
      default: return 16'hFFFF;
    endcase
  endfunction
  // inputs move 1 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk(input string n, input logic [2:0] k, input logic [15:0] g);
    if (k != 3'h7) cmp(n, 48'(sel(k)), 48'(g));
  endtask
  // bounded wait on the automatic flag; running out ends the run
  task automatic wflag(input logic [15:0] e);
    for (int i = 0; i < 40 && fl !== e; i++) tick(1);
    cmp("auto flag", 48'(e), 48'(fl));
    if (fl !== e) results();
  endtask
  task automatic results;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // =====================================================================
  // table of modes, then automatic loops, stall and reset by hand
  initial begin
    int n;
    tick(5);
    srst = 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      {analog_loop_enable, manual_remote_loop_enable, manual_digital_loop_enable, rpe, tpe, rai, tai} = {{16{r.c[6]}}, {16{r.c[5]}}, {16{r.c[4]}},
        {16{r.c[3]}}, {16{r.c[2]}}, {16{r.c[1]}}, {16{r.c[0]}}};
      tick(16);
      chk("line tx", r.tx, ltx);
      chk("system rx", r.rx, last);
      chk("rx detect", r.rd, rdet);
      chk("alarm watch", r.wa, watch);
      chk("tx detect", r.td, tdet);
      cmp("loop state", {{16{r.act[2]}}, {16{r.act[1]}}, {16{r.act[0]}}}, {aa, ra, da});
      cmp("clock ignored", 48'({16{r.act[1]}}), 48'(ig));
    end
    {analog_loop_enable, manual_remote_loop_enable, manual_digital_loop_enable, rpe, tpe, rai, tai} = '0;
    // automatic remote on channel 0 only; position stays put while active
    aen = 16'h0001;
    act = 16'h0001;
    tick(21);
    cmp("early flag", 48'h0, 48'(fl));
    tick(1);
    wflag(16'h0001);
    cmp("auto remote", 48'h1, 48'(ra));
    manual_digital_loop_enable = 16'h0001;
    tick(1);
    cmp("auto remote masked", 48'h0, 48'(ra));
    manual_digital_loop_enable = 16'h0;
    act = 16'h0;
    dea = 16'h0001;
    wflag(16'h0);
    dea = 16'h0;
    pos = 16'h0001;
    act = 16'h0001;
    wflag(16'h0001);
    cmp("auto digital", 48'h1, 48'(da));
    manual_remote_loop_enable = 16'h0001;
    tpe = 16'hFFFF;
    tick(16);
    cmp("dual state", 48'h0000_0001_0001, 48'({ra, da}));
    cmp("dual tx", 48'hAAAB, 48'(ltx));
    aen = 16'h0;
    wflag(16'h0);
    {manual_remote_loop_enable, tpe, pos} = '0;
    manual_digital_loop_enable = 16'h0001;
    aen = 16'h0001;
    tick(40);
    cmp("auto blocked", 48'h0, 48'({fl, ra}));
    {manual_digital_loop_enable, aen, act} = '0;
    // receiver stalls: ticks must stop instead of losing words
    stall = 1'b1;
    tick(40);
    n = 0;
    repeat (20) begin
      tick(1);
      n += int'(strobe);
    end
    cmp("stall strobes", 48'h0, 48'(n));
    cmp("held valid", 48'h1, 48'(valid));
    stall = 1'b0;
    analog_loop_enable = 16'hFFFF;
    tick(8);
    srst = 1'b1;
    tick(2);
    cmp("reset state", 48'h0, 48'({aa, fl, valid}));
    srst = 1'b0;
    tick(2);
    cmp("analog after reset", 48'hFFFF, 48'(aa));
    results();
  end
endmodule

// [verilog/llc_loopback.sv]
`timescale 1ns/1ps
// Functional notes
// - analog loop enable loops transmit into receive
// - analog loop still drives line; receive replaced
// - analog loop forces remote and digital off
// - analog: receive pattern over loop; no AIS
// - remote loop is manual or automatic
// - receive-side inband codes toggle automatic remote
// - dropping automatic enable ends automatic loop
// - flag shows automatic loop currently active
// - remote: receive data to shaper, system ignored
// - remote: transmit detectors still watch system data
// - remote priorities; transmit AIS disabled
// - digital loop is manual or automatic
// - transmit-side inband codes toggle automatic digital
// - digital: transmit data into decoder, line watched
// - digital priorities; receive AIS disabled
// - dual only manual remote; no automatic remote
// - dual: both streams loop, neither passes through
// - dual: receive detectors watch looped data
// - dual manual: remote loop over transmit pattern
// - dual automatic: no AIS, no transmit pattern
// =====================================================================
// loopback controller: one set of loop paths per line channel
module llc_loopback #(
  parameter int unsigned NUM_CH = llc_pkg::NUM_CH,
  parameter int unsigned AUTO_HOLD_CYCLES = 32'(llc_pkg::AUTO_HOLD_CYCLES),
  parameter int unsigned LINE_DIV = llc_pkg::LINE_DIV
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // per-channel loop control bits
  input wire logic [NUM_CH-1:0] i_analog_loop_enable,
  input wire logic [NUM_CH-1:0] i_manual_remote_loop_enable,
  input wire logic [NUM_CH-1:0] i_manual_digital_loop_enable,
  input wire logic [NUM_CH-1:0] i_automatic_loop_enable,
  input wire logic [NUM_CH-1:0] i_pattern_detector_position,
  // inband loop code detector results, level while code is seen
  input wire logic [NUM_CH-1:0] i_inband_loop_code_activate,
  input wire logic [NUM_CH-1:0] i_inband_loop_code_deactivate,
  // diagnostic generators
  input wire logic [NUM_CH-1:0] i_rx_pattern_gen_enable,
  input wire logic [NUM_CH-1:0] i_rx_pattern_gen_data,
  input wire logic [NUM_CH-1:0] i_tx_pattern_gen_enable,
  input wire logic [NUM_CH-1:0] i_tx_pattern_gen_data,
  input wire logic [NUM_CH-1:0] i_rx_ais_gen_request,
  input wire logic [NUM_CH-1:0] i_tx_ais_gen_request,
  // data streams entering the block
  input wire logic [NUM_CH-1:0] i_line_rx_data,
  input wire logic [NUM_CH-1:0] i_sys_tx_data,
  // system-side receive stream with back-pressure
  output logic o_sys_rx_valid,
  output logic [NUM_CH-1:0] o_sys_rx_data,
  input wire logic i_sys_rx_ready,
  // line-side transmit stream to the waveform shaper
  output logic o_line_tx_strobe,
  output logic [NUM_CH-1:0] o_line_tx_data,
  // streams handed to the detectors
  output logic [NUM_CH-1:0] o_rx_detect_data,
  output logic [NUM_CH-1:0] o_rx_alarm_watch_data,
  output logic [NUM_CH-1:0] o_tx_detect_data,
  // per-channel status
  output logic [NUM_CH-1:0] o_analog_loop_active,
  output logic [NUM_CH-1:0] o_remote_loop_active,
  output logic [NUM_CH-1:0] o_digital_loop_active,
  output logic [NUM_CH-1:0] o_automatic_loop_active_flag,
  output logic [NUM_CH-1:0] o_system_transmit_clock_ignored
);

  // hold counter must reach the full hold count itself; the hold count is in
  // reference cycles and is only shortened for simulation
  localparam int unsigned CNT_W = $clog2(AUTO_HOLD_CYCLES + 1);
  // divider width; a divide ratio below two leaves no room for the strobe to fall
  localparam int unsigned DIV_W = $clog2(LINE_DIV);

  // =====================================================================
  // line bit rate divider
  logic [DIV_W-1:0] div_cnt;
  logic line_tick;
  logic buf_in_ready;
  logic bit_step;

  // a step is a tick that the receive buffer is able to take;
  // a stalled receiver holds both line streams back, so no word is lost
  assign bit_step = line_tick & buf_in_ready;

  // free-running divider; tick is a one-cycle enable
  // the tick is registered so the step enable carries no decode glitch, and
  // the divider keeps running while stalled, so a refused tick waits a period
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      div_cnt <= '0;
      line_tick <= 1'b0;
    end else begin
      line_tick <= (div_cnt == DIV_W'(LINE_DIV - 1));
      div_cnt <= (div_cnt == DIV_W'(LINE_DIV - 1)) ? '0 : div_cnt + 1'b1;
    end
  end

  // =====================================================================
  // per-channel loop selection
  logic [NUM_CH-1:0] rx_word;
  logic [NUM_CH-1:0] tx_word;
  logic [NUM_CH-1:0] rx_src;
  logic [NUM_CH-1:0] alarm_src;
  logic [NUM_CH-1:0] rem_on;
  logic [NUM_CH-1:0] dig_on;
  logic [NUM_CH-1:0] auto_flag;

  // every channel below owns its own counter, state and flag
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      llc_pkg::llc_auto_t auto_state;
      llc_pkg::llc_auto_t next_auto_state;
      logic [CNT_W-1:0] hold_cnt;
      logic code_seen;
      logic held;
      logic analog_loop_enable;
      logic auto_rem;
      logic auto_dig;
      logic dual;

      assign analog_loop_enable = i_analog_loop_enable[ch];
      assign auto_rem = (auto_state == llc_pkg::LLC_AUTO_REMOTE);
      assign auto_dig = (auto_state == llc_pkg::LLC_AUTO_DIGITAL);
      // analog overrides both other loops whatever their enables say
      // automatic remote gives way to a manual digital loop, because the
      // inband detector then only sees the digitally looped stream
      assign rem_on[ch] = ~analog_loop_enable & (i_manual_remote_loop_enable[ch] |
        (auto_rem & ~i_manual_digital_loop_enable[ch]));
      assign dig_on[ch] = ~analog_loop_enable & (i_manual_digital_loop_enable[ch] | auto_dig);
      // dual means both loops survived the analog mask
      assign dual = rem_on[ch] & dig_on[ch];
      // either automatic loop lights the status flag
      assign auto_flag[ch] = auto_rem | auto_dig;

      // code that would move the state: activate when idle, else deactivate
      assign code_seen = (auto_state == llc_pkg::LLC_AUTO_IDLE) ?
        i_inband_loop_code_activate[ch] : i_inband_loop_code_deactivate[ch];
      // fires one cycle past the full hold, i.e. strictly more than it
      assign held = code_seen && (hold_cnt == CNT_W'(AUTO_HOLD_CYCLES));

      // persistence counter restarts whenever the awaited code drops
      // or the enable falls, so a partly held code must be seen in full again
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          hold_cnt <= '0;
        end else if (!code_seen || !i_automatic_loop_enable[ch] || held) begin
          hold_cnt <= '0;
        end else begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end

      // automatic loop entry and exit
      always_comb begin
        next_auto_state = auto_state;
        unique case (auto_state)
          llc_pkg::LLC_AUTO_IDLE: begin
            // analog blocks entry; the counter restarts and tries again
            if (held && !analog_loop_enable) begin
              if (i_pattern_detector_position[ch] == llc_pkg::PATTERN_DETECTOR_POSITION_TRANSMIT) begin
                next_auto_state = llc_pkg::LLC_AUTO_DIGITAL;
              end else if (!dig_on[ch]) begin
                // the detector sits inside the digital loop then
                next_auto_state = llc_pkg::LLC_AUTO_REMOTE;
              end
            end
          end
          llc_pkg::LLC_AUTO_REMOTE, llc_pkg::LLC_AUTO_DIGITAL: begin
            if (held) begin
              next_auto_state = llc_pkg::LLC_AUTO_IDLE;
            end
          end
          default: begin
            // the spare code is never entered; idle drops any stray loop
            next_auto_state = llc_pkg::LLC_AUTO_IDLE;
          end
        endcase
        // position is assumed steady while active; enable drop wins at once
        if (!i_automatic_loop_enable[ch]) begin
          next_auto_state = llc_pkg::LLC_AUTO_IDLE;
        end
      end

      // automatic state register; reset returns the channel to idle
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          auto_state <= llc_pkg::LLC_AUTO_IDLE;
        end else begin
          auto_state <= next_auto_state;
        end
      end

      // transmit path towards the waveform shaper
      // dual loops send the line word back whatever the generators ask
      always_comb begin
        if (rem_on[ch] && dual && i_manual_digital_loop_enable[ch]) begin
          tx_word[ch] = i_line_rx_data[ch];
        end else if (rem_on[ch] && dual) begin
          tx_word[ch] = i_line_rx_data[ch];
        end else if (i_tx_pattern_gen_enable[ch]) begin
          tx_word[ch] = i_tx_pattern_gen_data[ch];
        end else if (rem_on[ch]) begin
          tx_word[ch] = i_line_rx_data[ch];
        end else if (dig_on[ch] || analog_loop_enable) begin
          // digital ranks data over AIS; analog has no AIS at all
          tx_word[ch] = i_sys_tx_data[ch];
          // AIS only when no loop owns the transmit word
        end else if (i_tx_ais_gen_request[ch]) begin
          tx_word[ch] = llc_pkg::AIS_LEVEL;
        end else begin
          tx_word[ch] = i_sys_tx_data[ch];
        end
      end

      // receive source: analog takes the word about to go to the line
      // analog has already cleared dig_on, so the first two never compete
      always_comb begin
        if (dig_on[ch]) begin
          rx_src[ch] = i_sys_tx_data[ch];
        end else if (analog_loop_enable) begin
          rx_src[ch] = tx_word[ch];
        end else begin
          rx_src[ch] = i_line_rx_data[ch];
        end
        // alarm detectors keep watching the line except under analog loop
        alarm_src[ch] = analog_loop_enable ? tx_word[ch] : i_line_rx_data[ch];
      end

      // receive priority; AIS only where no loop replaces line data
      // this masks receive AIS in analog and in any digital loop, dual included
      always_comb begin
        if (i_rx_pattern_gen_enable[ch]) begin
          rx_word[ch] = i_rx_pattern_gen_data[ch];
        end else if (!analog_loop_enable && !dig_on[ch] && i_rx_ais_gen_request[ch]) begin
          rx_word[ch] = llc_pkg::AIS_LEVEL;
        end else begin
          rx_word[ch] = rx_src[ch];
        end
      end
    end
  endgenerate

  // =====================================================================
  // registered line-side and status outputs
  // detector streams move with the line step so they stay aligned with the
  // data word; a refused step leaves them showing the previous bit
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_line_tx_strobe <= 1'b0;
      o_line_tx_data <= '0;
      o_rx_detect_data <= '0;
      o_rx_alarm_watch_data <= '0;
      o_tx_detect_data <= '0;
    end else begin
      o_line_tx_strobe <= bit_step;
      if (bit_step) begin
        o_line_tx_data <= tx_word;
        o_rx_detect_data <= rx_src;
        o_rx_alarm_watch_data <= alarm_src;
        o_tx_detect_data <= i_sys_tx_data;
      end
    end
  end

  // loop state indications, refreshed every cycle
  // the analog indication follows its enable, which always takes effect
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_analog_loop_active <= '0;
      o_remote_loop_active <= '0;
      o_digital_loop_active <= '0;
      o_automatic_loop_active_flag <= '0;
      o_system_transmit_clock_ignored <= '0;
    end else begin
      o_analog_loop_active <= i_analog_loop_enable;
      o_remote_loop_active <= rem_on;
      o_digital_loop_active <= dig_on;
      o_automatic_loop_active_flag <= auto_flag;
      o_system_transmit_clock_ignored <= rem_on;
    end
  end

  // =====================================================================
  // system-side receive buffer
  // the buffer is offered a word on every tick; when full it refuses the
  // tick and no step happens, so both line directions stay in step
  llc_skid_buffer #(
    .WIDTH(NUM_CH)
  ) u_rx_buf (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_in_valid(line_tick),
    .i_in_data(rx_word),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_sys_rx_valid),
    .o_out_data(o_sys_rx_data),
    .i_out_ready(i_sys_rx_ready)
  );

endmodule

// [verilog/llc_pkg.sv]
// =====================================================================
// shared constants for the line loopback controller
package llc_pkg;

  // number of line channels handled side by side
  localparam int unsigned NUM_CH = 16;

  // reference clock period in nanoseconds (50 MHz)
  localparam longint unsigned CLK_PERIOD_NS = 64'h14;

  // inband code persistence time before a loop changes, in milliseconds
  localparam longint unsigned AUTO_HOLD_MS = 64'h13EC;

  // persistence time as reference clock cycles (least time, rounded up)
  localparam longint unsigned AUTO_HOLD_CYCLES =
    (AUTO_HOLD_MS * 64'hF4240 + CLK_PERIOD_NS - 64'h1) / CLK_PERIOD_NS;

  // reference cycles per line bit; 32 gives about 1.5625 Mbit/s
  localparam int unsigned LINE_DIV = 32'h20;

  // control bit positions inside the per-channel loop control byte
  localparam int unsigned LOOP_ANALOG_BIT = 0;
  localparam int unsigned LOOP_REMOTE_BIT = 1;
  localparam int unsigned LOOP_DIGITAL_BIT = 2;
  localparam int unsigned LOOP_AUTO_BIT = 3;

  // status bit carrying the automatic loop flag in the first status byte
  localparam int unsigned STAT_AUTO_LOOP_BIT = 7;

  // pattern detector position codes
  localparam logic PATTERN_DETECTOR_POSITION_RECEIVE = 1'b0;
  localparam logic PATTERN_DETECTOR_POSITION_TRANSMIT = 1'b1;

  // value driven while an alarm indication signal is generated
  localparam logic AIS_LEVEL = 1'b1;

  // automatic loop state; one bit flips on each usual step out of idle
  typedef enum logic [1:0] {
    LLC_AUTO_IDLE = 2'h0,
    LLC_AUTO_REMOTE = 2'h1,
    LLC_AUTO_DIGITAL = 2'h2
  } llc_auto_t;

endpackage

// [verilog/llc_skid_buffer.sv]
`timescale 1ns/1ps
// =====================================================================
// two-entry buffer: an output register plus one skid register
module llc_skid_buffer #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_srst,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  logic skid_valid;
  logic [WIDTH-1:0] skid_data;

  // full when the skid entry holds a word; ready is a plain flop inverse
  assign o_in_ready = ~skid_valid;

  // head entry: refilled from skid first so word order is kept
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end else if (!o_out_valid || i_out_ready) begin
      if (skid_valid) begin
        o_out_valid <= 1'b1;
        o_out_data <= skid_data;
      end else begin
        o_out_valid <= i_in_valid;
        o_out_data <= i_in_data;
      end
    end
  end

  // skid entry: catches the word offered while the head is stalled
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else if (!o_out_valid || i_out_ready) begin
      skid_valid <= 1'b0;
    end else if (i_in_valid && !skid_valid) begin
      skid_valid <= 1'b1;
      skid_data <= i_in_data;
    end
  end

endmodule
